//--- dv/global_control_assertions.sv
`default_nettype none
module global_control_assertions (
  // Clock and reset
  input wire logic       clk_in,
  input wire logic       sys_rst_in,
  // Watched pins
  input wire logic       sync_n_in,
  input wire logic       sdo_out,
  input wire logic       sdo_oe_out,
  input wire logic [3:0] channel_output_on_in,
  input wire logic [3:0] channel_boost_power_in,
  input wire logic [3:0] output_enable_out,
  input wire logic [3:0] boost_power_out,
  input wire logic [3:0] disabled_level_out,
  input wire logic       short_limit_8ma_out,
  input wire logic       watchdog_alarm_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking dc @(posedge clk_in);
  endclocking
  default disable iff (sys_rst_in);
  sequence s_quiet;
    sync_n_in [*8];
  endsequence
  sequence s_open;
    $rose(sdo_oe_out);
  endsequence
  AST_OUT_ALL: assert property (!$past(sys_rst_in) |-> output_enable_out ==
    $past(channel_output_on_in) || output_enable_out == 4'hF) else $error("oe mix");
  AST_BOOST_ALL: assert property (!$past(sys_rst_in) |-> boost_power_out ==
    $past(channel_boost_power_in) || boost_power_out == 4'hF) else $error("boost mix");
  AST_DIS_ENABLED: assert property ((disabled_level_out & output_enable_out) == 4'h0)
    else $error("dis on enabled");
  AST_DIS_UNIFORM: assert property (disabled_level_out == 4'h0 ||
    disabled_level_out == ~output_enable_out) else $error("dis mix");
  AST_RESET_CLEAR: assert property ($fell(sys_rst_in) |-> {output_enable_out,
    boost_power_out, disabled_level_out, short_limit_8ma_out, sdo_oe_out} == 14'h0)
    else $error("reset value");
  AST_ECHO_QUIET: assert property (s_quiet |-> !sdo_oe_out) else $error("sdo idle");
  AST_ECHO_LEAD: assert property (s_open |-> !sdo_out) else $error("sdo lead");
  AST_ALARM_HOLD: assert property (s_quiet ##0 watchdog_alarm_out |=>
    watchdog_alarm_out) else $error("alarm drop");
  AST_LIMIT_HOLD: assert property (s_quiet |=> $stable(short_limit_8ma_out))
    else $error("limit moved");
endmodule
bind global_control global_control_assertions chk_i (
  .clk_in(clk_in), .sys_rst_in(sys_rst_in), .sync_n_in(sync_n_in), .sdo_out(sdo_out),
  .sdo_oe_out(sdo_oe_out), .channel_output_on_in(channel_output_on_in),
  .channel_boost_power_in(channel_boost_power_in), .output_enable_out(output_enable_out),
  .boost_power_out(boost_power_out), .disabled_level_out(disabled_level_out),
  .short_limit_8ma_out(short_limit_8ma_out), .watchdog_alarm_out(watchdog_alarm_out));
`default_nettype wire

//--- dv/host_model.sv
`default_nettype none
module host_model (
  input  wire logic        clk_in,
  input  wire logic        sdo_in,
  output var  logic        sclk_out,
  output var  logic        sync_n_out,
  output var  logic        sdin_out,
  output var  logic [23:0] echo_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    sclk_out = 1'b1;
    sync_n_out = 1'b1;
    sdin_out = 1'b0;
    echo_out = 24'h0;
  end
  // Global bits only, never per-channel ones
  task automatic send(input logic [23:0] w, input int n);
    sync_n_out <= 1'b0;
    repeat (4) @(posedge clk_in);
    for (int i = 23; i > 23 - n; i--) begin
      sdin_out <= w[i];
      repeat (5) @(posedge clk_in);
      echo_out <= {echo_out[22:0], sdo_in};
      sclk_out <= 1'b0;
      repeat (5) @(posedge clk_in);
      sclk_out <= 1'b1;
    end
    sdin_out <= ~sdin_out;
    repeat (5) @(posedge clk_in);
    sync_n_out <= 1'b1;
    repeat (12) @(posedge clk_in);
  endtask
endmodule
`default_nettype wire

//--- dv/tb.sv
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_in = 1'b0;
  logic        sys_rst_in = 1'b1;
  logic        poc_pin_in = 1'b0;
  logic [3:0]  chan_on = 4'h0;
  logic [3:0]  chan_boost = 4'h0;
  logic [15:0] status = 16'h0;
  logic        sclk, sync_n, sdin, sdo, sdo_oe, short8, alarm;
  logic [3:0]  oe, boost, dis;
  logic [23:0] echo;
  int          miscompares = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  always #20 clk_in = ~clk_in;
  global_control #(.TIMEOUT0_CYCLES(20), .TIMEOUT1_CYCLES(40), .TIMEOUT2_CYCLES(60),
    .TIMEOUT3_CYCLES(80)) uut (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .sclk_in(sclk), .sync_n_in(sync_n),
    .sdin_in(sdin), .sdo_out(sdo), .sdo_oe_out(sdo_oe), .poc_pin_in(poc_pin_in),
    .channel_output_on_in(chan_on), .channel_boost_power_in(chan_boost),
    .status_in(status), .output_enable_out(oe), .boost_power_out(boost),
    .disabled_level_out(dis), .short_limit_8ma_out(short8), .watchdog_alarm_out(alarm));
  // Pulled-up line when the echo driver is off
  host_model host (.clk_in(clk_in), .sdo_in(sdo_oe ? sdo : 1'b1), .sclk_out(sclk),
    .sync_n_out(sync_n), .sdin_out(sdin), .echo_out(echo));
  function automatic logic [23:0] mc(input logic [12:0] d);
    return {8'h1C, 3'h1, d};
  endfunction
  task automatic chk(input string name, input logic [23:0] e, input logic [23:0] s);
    cmp_count++;
    if (s !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", name, e, s);
    end
  endtask
  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic t_fields;
    host.send(mc(13'h00FF), 24);
    chk("short", 24'h1, short8);
    chk("oe", 24'hF, oe);
    chk("boost", 24'hF, boost);
    host.send({8'h1C, 3'h0, 13'h0}, 24);
    host.send({8'h9C, 3'h1, 13'h0}, 24);
    host.send(mc(13'h0), 23);
    chk("short", 24'h1, short8);
    host.send(mc(13'h0010), 24);
    host.send(mc(13'h0), 24);
    chk("fields", 24'h0, {short8, oe, boost});
  endtask
  task automatic t_polarity;
    chan_on <= 4'h5;
    chan_boost <= 4'h3;
    poc_pin_in <= 1'b1;
    host.send(mc(13'h0), 24);
    chk("oe", 24'h5, oe);
    chk("boost", 24'h3, boost);
    chk("dis", 24'hA, dis);
    host.send(mc(13'h1000), 24);
    chk("dis", 24'h0, dis);
    poc_pin_in <= 1'b0;
    repeat (8) @(posedge clk_in);
    chk("dis", 24'hA, dis);
  endtask
  task automatic t_echo;
    status <= 16'hA5C3;
    host.send(mc(13'h0800), 24);
    host.send(mc(13'h0800), 24);
    chk("echo", {9'h0, status[15:1]}, echo);
    host.send(mc(13'h0), 24);
    host.send(mc(13'h0), 24);
    chk("echo", 24'hFFFFFF, echo);
  endtask
  task automatic t_watchdog;
    int n;
    for (int c = 0; c < 4; c++) begin
      host.send(mc({3'h1, c[1:0], 8'h0}), 24);
      chk("alarm", 24'h0, alarm);
      n = 0;
      while (alarm !== 1'b1 && n < 200) begin
        @(posedge clk_in);
        n++;
      end
      chk("period", 24'h1, 24'(n >= 20 * c + 8 && n <= 20 * c + 20));
    end
    host.send(mc(13'h0), 24);
    repeat (120) @(posedge clk_in);
    chk("alarm", 24'h0, alarm);
  endtask
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (16) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    repeat (4) @(posedge clk_in);
    chk("outs", 24'h0, {oe, boost, dis, short8, alarm, sdo_oe});
    t_fields();
    t_polarity();
    t_echo();
    t_watchdog();
    tally_and_finish();
  end
endmodule
`default_nettype wire

//--- verilog/global_control.sv
// Functional notes
// R1: A write frame with data-register select 111 and control-register select 001 loads this register.
// R2: The polarity field sets the level of every voltage output that is not enabled.
// R3: Polarity 0 makes a disabled output follow the power-on-condition pin.
// R4: Polarity 1 makes a disabled output take the inverse of the power-on-condition pin.
// R5: Polarity, status echo, watchdog enable and short limit select all reset to zero.
// R6: With status echo set, status is shifted out on the serial output during each write frame.
// R7: The interface watchdog runs only while its enable bit is set.
// R8: Timeout select 00, 01, 10, 11 gives 5, 10, 100, 200 ms.
// R9: Short limit select 0 means a 16 mA limit, 1 means 8 mA.
// R10: The global output enable turns on the outputs of all four channels together.
// R11: The host uses either the global output enable or the per-channel ones, never both.
// R12: The global boost power bit powers up all four boost converters together.
// R13: The host disables every output before clearing the global boost power bit.
// R14: The host uses either the global boost power bit or the per-channel ones, never both.
// R15: Data bit 7 and bits 3 to 0 of the main control write are ignored.
`default_nettype none
module global_control
  import main_ctrl_pkg::*;
#(
  parameter int unsigned TIMEOUT0_CYCLES = main_ctrl_pkg::WD_T0_CYCLES,
  parameter int unsigned TIMEOUT1_CYCLES = main_ctrl_pkg::WD_T1_CYCLES,
  parameter int unsigned TIMEOUT2_CYCLES = main_ctrl_pkg::WD_T2_CYCLES,
  parameter int unsigned TIMEOUT3_CYCLES = main_ctrl_pkg::WD_T3_CYCLES
) (
  // Clock and reset
  input  wire logic                                  clk_in,
  input  wire logic                                  sys_rst_in,
  // Serial pins
  input  wire logic                                  sclk_in,
  input  wire logic                                  sync_n_in,
  input  wire logic                                  sdin_in,
  output var  logic                                  sdo_out,
  output var  logic                                  sdo_oe_out,
  // Power-on-condition pin
  input  wire logic                                  poc_pin_in,
  // Per-channel controls and device status
  input  wire logic [main_ctrl_pkg::CHANNELS-1:0]    channel_output_on_in,
  input  wire logic [main_ctrl_pkg::CHANNELS-1:0]    channel_boost_power_in,
  input  wire logic [main_ctrl_pkg::STATUS_W-1:0]    status_in,
  // Channel drive
  output var  logic [main_ctrl_pkg::CHANNELS-1:0]    output_enable_out,
  output var  logic [main_ctrl_pkg::CHANNELS-1:0]    boost_power_out,
  output var  logic [main_ctrl_pkg::CHANNELS-1:0]    disabled_level_out,
  output var  logic                                  short_limit_8ma_out,
  // Watchdog
  output var  logic                                  watchdog_alarm_out
);
  import main_ctrl_pkg::*;

  typedef struct packed {
    logic                   sclk_s1;
    logic                   sclk_s2;
    logic                   sclk_s3;
    logic                   sync_s1;
    logic                   sync_s2;
    logic                   sync_s3;
    logic                   sdin_s1;
    logic                   sdin_s2;
    logic                   poc_s1;
    logic                   poc_s2;
    frame_state_type        state;
    logic [FRAME_BITS-1:0]  shift;
    logic [4:0]             bit_cnt;
    logic [FRAME_BITS-1:0]  echo_shift;
    logic                   sdo;
    logic                   sdo_oe;
    logic                   disabled_output_polarity;
    logic                   status_echo_on_write;
    logic                   watchdog_on;
    logic                   timeout_select_hi;
    logic                   timeout_select_lo;
    logic                   short_limit_select;
    logic                   global_output_on;
    logic                   global_boost_power;
    logic [WD_CNT_W-1:0]    wd_cnt;
    logic                   alarm;
    logic [CHANNELS-1:0]    out_en;
    logic [CHANNELS-1:0]    boost;
    logic [CHANNELS-1:0]    park;
  } state_type;

  localparam logic [4:0] FRAME_BITS_C = 5'(FRAME_BITS);

  function automatic logic [WD_CNT_W-1:0] timeout_reload(input logic [1:0] sel);
    unique case (sel)
      2'h0: timeout_reload = WD_CNT_W'(TIMEOUT0_CYCLES - 1);
      2'h1: timeout_reload = WD_CNT_W'(TIMEOUT1_CYCLES - 1);
      2'h2: timeout_reload = WD_CNT_W'(TIMEOUT2_CYCLES - 1);
      2'h3: timeout_reload = WD_CNT_W'(TIMEOUT3_CYCLES - 1);
    endcase
  endfunction

  function automatic logic is_main_write(input logic [FRAME_BITS-1:0] w);
    is_main_write = !w[RW_BIT]
                    && (w[DATA_REGISTER_SELECT_HI:DATA_REGISTER_SELECT_LO] == DATA_REGISTER_SELECT_CONTROL)
                    && (w[CONTROL_REGISTER_SELECT_HI:CONTROL_REGISTER_SELECT_LO] == CONTROL_REGISTER_SELECT_MAIN);
  endfunction

  state_type st;
  state_type next_st;

  logic sclk_fall;
  logic sclk_rise;
  logic sync_fall;
  logic sync_rise;
  logic level;

  always_comb begin
    next_st = st;
    // Synchronisers: first stage read only by second
    next_st.sclk_s1 = sclk_in;
    next_st.sclk_s2 = st.sclk_s1;
    next_st.sclk_s3 = st.sclk_s2;
    next_st.sync_s1 = sync_n_in;
    next_st.sync_s2 = st.sync_s1;
    next_st.sync_s3 = st.sync_s2;
    next_st.sdin_s1 = sdin_in;
    next_st.sdin_s2 = st.sdin_s1;
    next_st.poc_s1  = poc_pin_in;
    next_st.poc_s2  = st.poc_s1;

    sclk_fall = st.sclk_s3 && !st.sclk_s2;
    sclk_rise = !st.sclk_s3 && st.sclk_s2;
    sync_fall = st.sync_s3 && !st.sync_s2;
    sync_rise = !st.sync_s3 && st.sync_s2;

    unique case (st.state)
      FRAME_IDLE: begin
        next_st.sdo_oe = 1'b0;
        if (sync_fall) begin
          next_st.state      = FRAME_SHIFT;
          next_st.bit_cnt    = 5'h00;
          next_st.echo_shift = {{(FRAME_BITS-STATUS_W){1'b0}}, status_in};
          next_st.sdo        = 1'b0;
          next_st.sdo_oe     = st.status_echo_on_write; // R6
        end
      end
      FRAME_SHIFT: begin
        // Data taken on falling SCLK, echo moves on rising SCLK
        if (sclk_fall) begin
          next_st.shift = {st.shift[FRAME_BITS-2:0], st.sdin_s2};
          if (st.bit_cnt != 5'h1F) begin
            next_st.bit_cnt = st.bit_cnt + 5'h01;
          end
        end
        if (sclk_rise) begin
          next_st.sdo        = st.echo_shift[FRAME_BITS-1];
          next_st.echo_shift = {st.echo_shift[FRAME_BITS-2:0], 1'b0};
        end
        if (sync_rise) begin
          next_st.sdo_oe = 1'b0;
          next_st.state  = (st.bit_cnt == FRAME_BITS_C) ? FRAME_COMMIT : FRAME_IDLE;
        end
      end
      FRAME_COMMIT: begin
        next_st.state = FRAME_IDLE;
        if (is_main_write(st.shift)) begin // R1
          // Bit 7 and bits 3..0 are not stored
          next_st.disabled_output_polarity = st.shift[POLARITY_BIT]; // R2 R15
          next_st.status_echo_on_write     = st.shift[ECHO_BIT];
          next_st.watchdog_on              = st.shift[WD_ON_BIT];
          next_st.timeout_select_hi        = st.shift[WD_SEL_HI];
          next_st.timeout_select_lo        = st.shift[WD_SEL_LO];
          next_st.short_limit_select       = st.shift[SHORT_LIMIT_BIT];
          next_st.global_output_on         = st.shift[OUT_ALL_BIT];
          next_st.global_boost_power       = st.shift[BOOST_ALL_BIT];
        end
      end
      default: begin
        next_st.state  = FRAME_IDLE;
        next_st.sdo_oe = 1'b0;
      end
    endcase

    // Watchdog: any complete frame refreshes it and clears the alarm
    // Reload from the fields being written, so a new timeout applies at once
    if (!st.watchdog_on || st.state == FRAME_COMMIT) begin // R7
      next_st.wd_cnt = timeout_reload({next_st.timeout_select_hi,
                                       next_st.timeout_select_lo}); // R8
      if (st.state == FRAME_COMMIT) begin
        next_st.alarm = 1'b0;
      end
    end else if (st.wd_cnt == '0) begin
      next_st.alarm  = 1'b1;
      next_st.wd_cnt = timeout_reload({st.timeout_select_hi, st.timeout_select_lo}); // R8
    end else begin
      next_st.wd_cnt = st.wd_cnt - WD_CNT_W'(1);
    end

    // Level of a parked output
    level = st.poc_s2 ^ st.disabled_output_polarity; // R3 R4
    for (int i = 0; i < CHANNELS; i++) begin
      next_st.out_en[i] = channel_output_on_in[i] | st.global_output_on; // R10
      next_st.boost[i]  = channel_boost_power_in[i] | st.global_boost_power; // R12
      next_st.park[i]   = !next_st.out_en[i] && level; // R2
    end

    if (sys_rst_in) begin
      next_st                          = '0;
      next_st.state                    = FRAME_IDLE;
      // Idle level of the serial clock is high: no false edge after reset
      next_st.sclk_s1                  = 1'b1;
      next_st.sclk_s2                  = 1'b1;
      next_st.sclk_s3                  = 1'b1;
      next_st.sync_s1                  = 1'b1;
      next_st.sync_s2                  = 1'b1;
      next_st.sync_s3                  = 1'b1;
      next_st.disabled_output_polarity = POLARITY_RST; // R5
      next_st.status_echo_on_write     = ECHO_RST; // R5
      next_st.watchdog_on              = WD_ON_RST; // R5
      next_st.timeout_select_hi        = WD_SEL_RST[1];
      next_st.timeout_select_lo        = WD_SEL_RST[0];
      next_st.short_limit_select       = SHORT_LIMIT_RST; // R5
      next_st.global_output_on         = OUT_ALL_RST;
      next_st.global_boost_power       = BOOST_ALL_RST;
      next_st.wd_cnt                   = WD_CNT_W'(TIMEOUT0_CYCLES - 1);
    end
  end

  always_ff @(posedge clk_in) begin
    st <= next_st;
  end

  assign sdo_out             = st.sdo;
  assign sdo_oe_out          = st.sdo_oe;
  assign output_enable_out   = st.out_en;
  assign boost_power_out     = st.boost;
  assign disabled_level_out  = st.park;
  assign short_limit_8ma_out = st.short_limit_select; // R9
  assign watchdog_alarm_out  = st.alarm;
endmodule
`default_nettype wire

//--- verilog/main_ctrl_pkg.sv
`default_nettype none
package main_ctrl_pkg;
  // Serial frame layout, 24 bits, MSB first
  localparam int unsigned FRAME_BITS      = 24;
  localparam int unsigned RW_BIT          = 23;
  localparam int unsigned DATA_REGISTER_SELECT_HI         = 20;
  localparam int unsigned DATA_REGISTER_SELECT_LO         = 18;
  localparam int unsigned CONTROL_REGISTER_SELECT_HI         = 15;
  localparam int unsigned CONTROL_REGISTER_SELECT_LO         = 13;
  localparam logic [2:0]  DATA_REGISTER_SELECT_CONTROL    = 3'h7;
  localparam logic [2:0]  CONTROL_REGISTER_SELECT_MAIN       = 3'h1;

  // Main control field positions
  localparam int unsigned POLARITY_BIT    = 12;
  localparam int unsigned ECHO_BIT        = 11;
  localparam int unsigned WD_ON_BIT       = 10;
  localparam int unsigned WD_SEL_HI       = 9;
  localparam int unsigned WD_SEL_LO       = 8;
  localparam int unsigned SHORT_LIMIT_BIT = 6;
  localparam int unsigned OUT_ALL_BIT     = 5;
  localparam int unsigned BOOST_ALL_BIT   = 4;

  // Reset values of the fields
  localparam logic       POLARITY_RST     = 1'b0;
  localparam logic       ECHO_RST         = 1'b0;
  localparam logic       WD_ON_RST        = 1'b0;
  localparam logic [1:0] WD_SEL_RST       = 2'h0;
  localparam logic       SHORT_LIMIT_RST  = 1'b0;
  localparam logic       OUT_ALL_RST      = 1'b0;
  localparam logic       BOOST_ALL_RST    = 1'b0;

  // Watchdog timing
  localparam int unsigned CLK_KHZ         = 25000;
  localparam int unsigned WD_T0_MS        = 5;
  localparam int unsigned WD_T1_MS        = 10;
  localparam int unsigned WD_T2_MS        = 100;
  localparam int unsigned WD_T3_MS        = 200;
  localparam int unsigned WD_T0_CYCLES    = WD_T0_MS * CLK_KHZ;
  localparam int unsigned WD_T1_CYCLES    = WD_T1_MS * CLK_KHZ;
  localparam int unsigned WD_T2_CYCLES    = WD_T2_MS * CLK_KHZ;
  localparam int unsigned WD_T3_CYCLES    = WD_T3_MS * CLK_KHZ;
  localparam int unsigned WD_CNT_W        = 23;

  localparam int unsigned CHANNELS        = 4;
  localparam int unsigned STATUS_W        = 16;

  typedef enum logic [1:0] {
    FRAME_IDLE   = 2'h0,
    FRAME_SHIFT  = 2'h1,
    FRAME_COMMIT = 2'h3
  } frame_state_type;
endpackage
`default_nettype wire
